//--- hw/scw_pkg.sv
// constants, register map and carrier types of the serial configuration write port
package scw_pkg;
    // serial word layout
    localparam int SCW_WORD_BITS = 24;
    localparam int SCW_ADDR_BITS = 8;
    localparam int SCW_DATA_BITS = 16;
    localparam logic [4:0] SCW_LAST_BIT = 5'd23;
    localparam int SCW_SRST_BIT = 5;
    localparam logic [7:0] SCW_ADDR_SRST = 8'h00;

    // register slots held by the bank
    localparam int SCW_NREG = 11;
    localparam int SCW_IX_SEL = 0;
    localparam int SCW_IX_PDN = 1;
    localparam int SCW_IX_DRV = 2;
    localparam int SCW_IX_TERM = 3;
    localparam int SCW_IX_LFNS = 4;
    localparam int SCW_IX_G0 = 5;
    localparam int SCW_IX_G1 = 6;
    localparam int SCW_IX_G2 = 7;
    localparam int SCW_IX_PAT = 8;
    localparam int SCW_IX_C1 = 9;
    localparam int SCW_IX_C2 = 10;
    localparam logic [7:0] SCW_ADDR [SCW_NREG] = '{8'h03, 8'h0f, 8'h11, 8'h12, 8'h14,
        8'h16, 8'h17, 8'h18, 8'h25, 8'h26, 8'h27};
    // drive code default stands for the 3.5 mA setting
    localparam logic [15:0] SCW_DRV_DEFAULT = 16'h0000;
    localparam logic [15:0] SCW_DEFAULT [SCW_NREG] = '{16'h0020, 16'h0000, SCW_DRV_DEFAULT,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

    // field positions
    localparam int SCW_CODE_W = 3;
    localparam int SCW_SEL_BIT = 5;
    localparam int SCW_PART_BIT = 8;
    localparam int SCW_FULL_BIT = 9;
    localparam int SCW_PINCFG_BIT = 10;
    localparam int SCW_BCLK_LSB = 0;
    localparam int SCW_FCLK_LSB = 4;
    localparam int SCW_DAT_LSB = 8;
    localparam int SCW_TERM_EN_BIT = 14;
    localparam int SCW_RAMP_BIT = 6;
    localparam int SCW_DUAL_BIT = 5;
    localparam int SCW_SINGLE_BIT = 4;
    localparam int SCW_C1_MSB_LSB = 0;
    localparam int SCW_C2_MSB_LSB = 2;
    localparam int SCW_LOW_LSB = 6;
    localparam int SCW_G2_W = 8;

    // timing of the internal gain-controller link
    localparam int SCW_CLK_NS = 10;
    localparam int SCW_GAIN_HALF_NS = 40;
    localparam logic [3:0] SCW_GAIN_HALF_CYC = 4'((SCW_GAIN_HALF_NS + SCW_CLK_NS - 1) / SCW_CLK_NS);
    localparam int SCW_VEC_BITS = 40;
    localparam logic [5:0] SCW_VEC_LAST = 6'd39;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] data;
    } scw_word_t;

    typedef struct packed {
        logic gain_ctrl_select;
        logic [7:0] channel_power_down;
        logic partial_sleep;
        logic full_sleep;
        logic sleep_pin_config;
        logic [2:0] bitclk_drive_code;
        logic [2:0] frameclk_drive_code;
        logic [2:0] data_drive_code;
        logic term_enable;
        logic [2:0] bitclk_term_code;
        logic [2:0] frameclk_term_code;
        logic [2:0] data_term_code;
        logic [7:0] low_freq_suppress_enable;
        logic ramp_enable;
        logic two_code_pattern_enable;
        logic one_code_pattern_enable;
        logic [11:0] first_custom_code;
        logic [11:0] second_custom_code;
    } scw_cfg_t;
endpackage

//--- hw/scw_sync.sv
// two-flop level synchroniser, one lane per bit
`timescale 1ns/1ps
module scw_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= INIT;
            o_sync <= INIT;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

//--- hw/scw_gain_ser.sv
// serialiser for the 40-bit gain-controller vector, bit 0 first
`timescale 1ns/1ps
module scw_gain_ser (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic [39:0] i_vector,
    output logic o_sclk,
    output logic o_serial_in_line,
    output logic o_busy
);
    typedef enum logic [1:0] {
        SCW_GS_IDLE = 2'b01,
        SCW_GS_SHIFT = 2'b10
    } scw_gs_t;

    scw_gs_t st_q;
    logic [3:0] div_q;
    logic [5:0] bit_q;
    logic [39:0] vec_q;
    wire half_done = (div_q == scw_pkg::SCW_GAIN_HALF_CYC - 4'd1);

    // a new start restarts the frame so the latest vector always wins
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= SCW_GS_IDLE;
            div_q <= 4'h0;
            bit_q <= 6'h00;
            vec_q <= 40'h0;
            o_sclk <= 1'b0;
            o_serial_in_line <= 1'b0;
            o_busy <= 1'b0;
        end else if (i_start) begin
            st_q <= SCW_GS_SHIFT;
            div_q <= 4'h0;
            bit_q <= 6'h00;
            vec_q <= i_vector;
            o_sclk <= 1'b0;
            o_serial_in_line <= i_vector[0];
            o_busy <= 1'b1;
        end else begin
            case (st_q)
                SCW_GS_IDLE: begin
                    o_sclk <= 1'b0;
                    o_busy <= 1'b0;
                end
                SCW_GS_SHIFT: begin
                    div_q <= half_done ? 4'h0 : div_q + 4'h1;
                    if (half_done) begin
                        o_sclk <= ~o_sclk;
                        // data moves on the falling edge, stable at the rise
                        if (o_sclk) begin
                            if (bit_q == scw_pkg::SCW_VEC_LAST) begin
                                st_q <= SCW_GS_IDLE;
                                o_busy <= 1'b0;
                            end else begin
                                bit_q <= bit_q + 6'h01;
                                o_serial_in_line <= vec_q[bit_q + 6'h01];
                            end
                        end
                    end
                end
                default: st_q <= SCW_GS_IDLE;
            endcase
        end
    end

    chk_ser_frame_len: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_busy) && !i_start [*1] ##1 !i_start [*1] |-> o_busy)
        else $error("gain serialiser dropped busy early");
    chk_ser_clk_idle: assert property (@(posedge i_clk) disable iff (i_rst)
        !o_busy && !i_start |=> !o_sclk)
        else $error("gain clock toggles while idle");
endmodule

//--- hw/scw_port.sv
// write-only serial configuration port and its register bank
`timescale 1ns/1ps
// Behaviour
// - select low enables shifting; high blocks it
// - data sampled on each serial clock rise
// - every 24th rise loads the addressed register
// - trailing partial word discarded at select rise
// - several words per select period all load
// - eight address bits then sixteen data bits
// - any serial rate to 20MHz, any duty
// - low reset pin restores all defaults
// - soft reset bit restores defaults, self-clears
// - gain vector sent on 16/17/18 write, enable high
// - per-channel power-down bits in register 0f
// - partial, complete and pin-config sleep modes
// - termination enable gates three termination codes
// - at most one test pattern selected
// - custom codes join two MSBs, ten LSBs
module scw_port (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sel_n,
    input wire logic i_sclk,
    input wire logic i_serial_in_line,
    input wire logic i_hw_reset_pin_n,
    input wire logic i_gain_sequencer_enable_pin,
    output scw_pkg::scw_cfg_t o_cfg,
    output logic o_gain_ctrl_serial_clock,
    output logic o_gain_ctrl_serial_word
);
    // lane order of the synchroniser
    localparam int LN_SCLK = 0;
    localparam int LN_SEL = 1;
    localparam int LN_DAT = 2;
    localparam int LN_RST = 3;
    localparam int LN_EN = 4;
    localparam logic [4:0] SYNC_INIT = 5'h0a;
    // custom code split between the pattern register and its own register
    localparam int MSB_W = 2;
    localparam int LOW_W = 10;

    logic [4:0] pins_s;
    logic sclk_prev_q;
    logic dat_prev_q;
    logic [4:0] bit_cnt_q;
    logic [23:0] shift_q;
    logic wr_stb_q;
    logic srst_q;
    logic start_q;
    logic [15:0] regs_q [scw_pkg::SCW_NREG];
    scw_pkg::scw_cfg_t cfg_d;
    logic [39:0] gain_vec;
    logic gain_busy;

    // all pins come from another domain; the serial clock is only sampled
    scw_sync #(
        .W(5),
        .INIT(SYNC_INIT)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async({i_gain_sequencer_enable_pin, i_hw_reset_pin_n, i_serial_in_line, i_sel_n, i_sclk}),
        .o_sync(pins_s)
    );

    wire sclk_s = pins_s[LN_SCLK];
    wire sel_act = ~pins_s[LN_SEL];
    wire rst_pin_s = pins_s[LN_RST];
    wire en_s = pins_s[LN_EN];
    // edge found from two samples, so duty cycle does not matter
    wire sclk_rise = sclk_s & ~sclk_prev_q;
    wire take_bit = sclk_rise & sel_act;
    wire word_end = take_bit & (bit_cnt_q == scw_pkg::SCW_LAST_BIT);
    scw_pkg::scw_word_t wr_word;
    assign wr_word = shift_q;
    wire cfg_clear = srst_q | ~rst_pin_s;

    // history taps for edge finding and for the bit seen before the rise
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sclk_prev_q <= 1'b0;
            dat_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            dat_prev_q <= pins_s[LN_DAT];
        end
    end

    // data is taken from the sample before the rise: host data changes
    // after the fall, so that sample is clear of the short hold window
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            shift_q <= 24'h0;
        end else if (take_bit) begin
            shift_q <= {shift_q[22:0], dat_prev_q};
        end
    end

    // bit counter wraps per word and drops a partial word at select rise
    // a host that stops mid-word loses only that word, never the next one
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bit_cnt_q <= 5'h00;
        end else if (!sel_act) begin
            bit_cnt_q <= 5'h00;
        end else if (word_end) begin
            bit_cnt_q <= 5'h00;
        end else if (take_bit) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    // commit strobe one cycle after the 24th rise, when shift_q is whole
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_stb_q <= 1'b0;
        end else begin
            wr_stb_q <= word_end;
        end
    end

    wire srst_hit = wr_stb_q & (wr_word.addr == scw_pkg::SCW_ADDR_SRST) & wr_word.data[scw_pkg::SCW_SRST_BIT];
    wire gain_hit = wr_stb_q & ((wr_word.addr == scw_pkg::SCW_ADDR[scw_pkg::SCW_IX_G0])
        | (wr_word.addr == scw_pkg::SCW_ADDR[scw_pkg::SCW_IX_G1])
        | (wr_word.addr == scw_pkg::SCW_ADDR[scw_pkg::SCW_IX_G2]));

    // soft reset bit lives one cycle only, so it clears itself
    // the clear lands the cycle after the commit, so the write never sticks
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            srst_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            srst_q <= srst_hit;
            start_q <= gain_hit & en_s & rst_pin_s;
        end
    end

    // one register per mapped address; other addresses are ignored
    for (genvar g = 0; g < scw_pkg::SCW_NREG; g++) begin : g_reg
        wire hit = wr_stb_q & (wr_word.addr == scw_pkg::SCW_ADDR[g]);
        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                regs_q[g] <= scw_pkg::SCW_DEFAULT[g];
            end else if (cfg_clear) begin
                regs_q[g] <= scw_pkg::SCW_DEFAULT[g];
            end else if (hit) begin
                regs_q[g] <= wr_word.data;
            end
        end
    end

    // channel n sits at D(4-n) for 1..4 and at D(n-1) for 5..8
    function automatic logic [7:0] chan_map(input logic [15:0] r);
        chan_map = {r[7:4], r[0], r[1], r[2], r[3]};
    endfunction

    wire [15:0] r_pdn = regs_q[scw_pkg::SCW_IX_PDN];
    wire [15:0] r_drv = regs_q[scw_pkg::SCW_IX_DRV];
    wire [15:0] r_term = regs_q[scw_pkg::SCW_IX_TERM];
    wire [15:0] r_pat = regs_q[scw_pkg::SCW_IX_PAT];
    wire term_on = r_term[scw_pkg::SCW_TERM_EN_BIT];
    wire pat_r = r_pat[scw_pkg::SCW_RAMP_BIT];
    wire pat_d = r_pat[scw_pkg::SCW_DUAL_BIT];
    wire pat_s = r_pat[scw_pkg::SCW_SINGLE_BIT];

    // field decode of the bank
    always_comb begin
        cfg_d = '0;
        cfg_d.gain_ctrl_select = regs_q[scw_pkg::SCW_IX_SEL][scw_pkg::SCW_SEL_BIT];
        cfg_d.channel_power_down = chan_map(r_pdn);
        cfg_d.partial_sleep = r_pdn[scw_pkg::SCW_PART_BIT];
        // the two sleep selections exclude each other
        cfg_d.full_sleep = r_pdn[scw_pkg::SCW_FULL_BIT] & ~r_pdn[scw_pkg::SCW_PINCFG_BIT];
        cfg_d.sleep_pin_config = r_pdn[scw_pkg::SCW_PINCFG_BIT] & ~r_pdn[scw_pkg::SCW_FULL_BIT];
        cfg_d.bitclk_drive_code = r_drv[scw_pkg::SCW_BCLK_LSB +: scw_pkg::SCW_CODE_W];
        cfg_d.frameclk_drive_code = r_drv[scw_pkg::SCW_FCLK_LSB +: scw_pkg::SCW_CODE_W];
        cfg_d.data_drive_code = r_drv[scw_pkg::SCW_DAT_LSB +: scw_pkg::SCW_CODE_W];
        cfg_d.term_enable = term_on;
        // codes only reach the buffers while termination is enabled
        if (term_on) begin
            cfg_d.bitclk_term_code = r_term[scw_pkg::SCW_BCLK_LSB +: scw_pkg::SCW_CODE_W];
            cfg_d.frameclk_term_code = r_term[scw_pkg::SCW_FCLK_LSB +: scw_pkg::SCW_CODE_W];
            cfg_d.data_term_code = r_term[scw_pkg::SCW_DAT_LSB +: scw_pkg::SCW_CODE_W];
        end
        cfg_d.low_freq_suppress_enable = chan_map(regs_q[scw_pkg::SCW_IX_LFNS]);
        // a mixed selection enables nothing rather than a guess
        cfg_d.ramp_enable = pat_r & ~pat_d & ~pat_s;
        cfg_d.two_code_pattern_enable = pat_d & ~pat_r & ~pat_s;
        cfg_d.one_code_pattern_enable = pat_s & ~pat_r & ~pat_d;
        cfg_d.first_custom_code = {r_pat[scw_pkg::SCW_C1_MSB_LSB +: MSB_W],
            regs_q[scw_pkg::SCW_IX_C1][scw_pkg::SCW_LOW_LSB +: LOW_W]};
        cfg_d.second_custom_code = {r_pat[scw_pkg::SCW_C2_MSB_LSB +: MSB_W],
            regs_q[scw_pkg::SCW_IX_C2][scw_pkg::SCW_LOW_LSB +: LOW_W]};
    end

    // outputs are registered; there is no path back to the host
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cfg <= '0;
        end else begin
            o_cfg <= cfg_d;
        end
    end

    // vector rebuilt from the bank, so any of the three writes resends it all
    assign gain_vec = {regs_q[scw_pkg::SCW_IX_G2][scw_pkg::SCW_G2_W-1:0],
        regs_q[scw_pkg::SCW_IX_G1], regs_q[scw_pkg::SCW_IX_G0]};

    // the vector is already updated when start_q fires
    scw_gain_ser u_gain (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_start(start_q),
        .i_vector(gain_vec),
        .o_sclk(o_gain_ctrl_serial_clock),
        .o_serial_in_line(o_gain_ctrl_serial_word),
        .o_busy(gain_busy)
    );

    // checks on the serial front end and the bank
    chk_sel_high_idle: assert property (@(posedge i_clk) disable iff (i_rst)
        !sel_act |=> bit_cnt_q == 5'h00 && $stable(shift_q))
        else $error("bits shifted while select is high");
    chk_bit_sampled: assert property (@(posedge i_clk) disable iff (i_rst)
        take_bit |=> shift_q[0] == $past(dat_prev_q) && shift_q[23:1] == $past(shift_q[22:0]))
        else $error("serial bit not taken on the rise");
    chk_word_commit: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_stb_q |-> $past(take_bit) && $past(bit_cnt_q) == scw_pkg::SCW_LAST_BIT)
        else $error("commit not on the 24th rise");
    chk_partial_drop: assert property (@(posedge i_clk) disable iff (i_rst)
        !sel_act ##1 !sel_act |-> !wr_stb_q)
        else $error("partial word committed after select rose");
    chk_next_word: assert property (@(posedge i_clk) disable iff (i_rst)
        word_end |=> bit_cnt_q == 5'h00)
        else $error("counter not restarted after a word");
    chk_data_lands: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_stb_q && wr_word.addr == scw_pkg::SCW_ADDR[scw_pkg::SCW_IX_C2] && !cfg_clear
        |=> regs_q[scw_pkg::SCW_IX_C2] == $past(wr_word.data))
        else $error("addressed register missed its data");
    chk_pin_reset: assert property (@(posedge i_clk) disable iff (i_rst)
        !rst_pin_s |=> regs_q[scw_pkg::SCW_IX_PAT] == scw_pkg::SCW_DEFAULT[scw_pkg::SCW_IX_PAT]
        && regs_q[scw_pkg::SCW_IX_SEL] == scw_pkg::SCW_DEFAULT[scw_pkg::SCW_IX_SEL])
        else $error("reset pin left a register off default");
    chk_soft_reset: assert property (@(posedge i_clk) disable iff (i_rst)
        srst_hit |=> srst_q ##1 (!srst_q && regs_q[scw_pkg::SCW_IX_PDN] == scw_pkg::SCW_DEFAULT[scw_pkg::SCW_IX_PDN]))
        else $error("soft reset did not restore or self-clear");
    chk_drive_default: assert property (@(posedge i_clk) disable iff (i_rst)
        cfg_clear |=> regs_q[scw_pkg::SCW_IX_DRV] == scw_pkg::SCW_DRV_DEFAULT)
        else $error("drive codes not back at default");
    chk_suppress_default: assert property (@(posedge i_clk) disable iff (i_rst)
        cfg_clear |=> regs_q[scw_pkg::SCW_IX_LFNS] == scw_pkg::SCW_DEFAULT[scw_pkg::SCW_IX_LFNS])
        else $error("noise suppression not back at default");

    // checks on the gain link trigger
    chk_gain_start: assert property (@(posedge i_clk) disable iff (i_rst)
        start_q |-> $past(gain_hit) && $past(en_s))
        else $error("gain link started without cause");
    chk_gain_runs: assert property (@(posedge i_clk) disable iff (i_rst)
        start_q |=> gain_busy)
        else $error("gain link did not start");
    chk_gain_gated: assert property (@(posedge i_clk) disable iff (i_rst)
        gain_hit && !en_s |=> !start_q)
        else $error("gain link started with enable low");

    // decoded outputs follow the bank one clock later
    chk_pdn_ch1: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_stb_q && wr_word.addr == scw_pkg::SCW_ADDR[scw_pkg::SCW_IX_PDN] && !cfg_clear
        ##1 !cfg_clear |=> o_cfg.channel_power_down[0] == $past(wr_word.data[3], 2))
        else $error("channel one power-down bit misplaced");
    chk_pdn_ch8: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_stb_q && wr_word.addr == scw_pkg::SCW_ADDR[scw_pkg::SCW_IX_PDN] && !cfg_clear
        ##1 !cfg_clear |=> o_cfg.channel_power_down[7] == $past(wr_word.data[7], 2))
        else $error("channel eight power-down bit misplaced");
    chk_partial_sleep: assert property (@(posedge i_clk) disable iff (i_rst)
        o_cfg.partial_sleep == $past(r_pdn[scw_pkg::SCW_PART_BIT]))
        else $error("partial sleep bit not decoded");
    chk_term_gated: assert property (@(posedge i_clk) disable iff (i_rst)
        !o_cfg.term_enable |-> o_cfg.bitclk_term_code == 3'h0 && o_cfg.frameclk_term_code == 3'h0
        && o_cfg.data_term_code == 3'h0)
        else $error("termination code passed while termination is off");
    chk_pattern_one: assert property (@(posedge i_clk) disable iff (i_rst)
        $onehot0({o_cfg.ramp_enable, o_cfg.two_code_pattern_enable, o_cfg.one_code_pattern_enable}))
        else $error("more than one test pattern active");
    chk_custom_one: assert property (@(posedge i_clk) disable iff (i_rst)
        o_cfg.first_custom_code == $past({r_pat[scw_pkg::SCW_C1_MSB_LSB +: MSB_W],
        regs_q[scw_pkg::SCW_IX_C1][scw_pkg::SCW_LOW_LSB +: LOW_W]}))
        else $error("first custom code not joined from its parts");
    chk_custom_two: assert property (@(posedge i_clk) disable iff (i_rst)
        o_cfg.second_custom_code == $past({r_pat[scw_pkg::SCW_C2_MSB_LSB +: MSB_W],
        regs_q[scw_pkg::SCW_IX_C2][scw_pkg::SCW_LOW_LSB +: LOW_W]}))
        else $error("second custom code not joined from its parts");

    cov_two_words: cover property (@(posedge i_clk) disable iff (i_rst)
        wr_stb_q ##[1:600] wr_stb_q);
    cov_soft_reset: cover property (@(posedge i_clk) disable iff (i_rst) srst_q);
    cov_gain_send: cover property (@(posedge i_clk) disable iff (i_rst) start_q ##[1:400] !gain_busy);
    cov_partial: cover property (@(posedge i_clk) disable iff (i_rst)
        sel_act && bit_cnt_q != 5'h00 ##1 !sel_act);
    cov_pin_reset: cover property (@(posedge i_clk) disable iff (i_rst)
        !rst_pin_s ##1 rst_pin_s);
endmodule

//--- bench/scw_host.sv
// host controller model driving the serial configuration pins
`timescale 1ns/1ps
module scw_host (
    input wire logic i_clk,
    output logic o_sel_n,
    output logic o_sclk,
    output logic o_serial_in_line
);
    initial begin
        o_sel_n = 1'b1;
        o_sclk = 1'b0;
        o_serial_in_line = 1'b0;
    end
    // select falls six clocks (60 ns) ahead of the first rise
    task automatic start();
        @(posedge i_clk) o_sel_n <= 1'b0;
    endtask
    // 80 ns bit, 50 ns low and 30 ns high, so duty is not 50 percent
    task automatic put_bit(input logic b);
        @(posedge i_clk);
        o_sclk <= 1'b0;
        o_serial_in_line <= b;
        repeat (4) @(posedge i_clk);
        @(posedge i_clk) o_sclk <= 1'b1;
        repeat (2) @(posedge i_clk);
    endtask
    // address first, then data, most significant bit first
    task automatic word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) put_bit(w[i]);
    endtask
    // stray bits, never a whole word
    task automatic bits8(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) put_bit(b[i]);
    endtask
    // released data shows the inverse, so a stale level cannot pass
    task automatic stop();
        @(posedge i_clk) o_sclk <= 1'b0;
        repeat (2) @(posedge i_clk);
        @(posedge i_clk);
        o_sel_n <= 1'b1;
        o_serial_in_line <= ~o_serial_in_line;
    endtask
endmodule

//--- bench/tb.sv
// self-checking bench for the serial configuration write port
`timescale 1ns/1ps
module tb;
    localparam int CW = $bits(scw_pkg::scw_cfg_t);
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic hw_n = 1'b1;
    logic gen = 1'b0;
    logic sel_n, sclk, serial_in_line, gclk, gdat;
    scw_pkg::scw_cfg_t o_cfg, exp_c, def_c;
    logic [39:0] vec;
    int fails = 0;
    int tests_run = 0;
    int n;

    always #5 i_clk = ~i_clk;

    scw_host host (.i_clk(i_clk), .o_sel_n(sel_n), .o_sclk(sclk), .o_serial_in_line(serial_in_line));
    scw_port uut (.i_clk(i_clk), .i_rst(i_rst), .i_sel_n(sel_n), .i_sclk(sclk),
        .i_serial_in_line(serial_in_line), .i_hw_reset_pin_n(hw_n), .i_gain_sequencer_enable_pin(gen),
        .o_cfg(o_cfg), .o_gain_ctrl_serial_clock(gclk), .o_gain_ctrl_serial_word(gdat));

    task automatic close_out();
        if (fails == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input string w, input logic [CW-1:0] e, input logic [CW-1:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic ck(input string w);
        cmp(w, exp_c, o_cfg);
    endtask
    // whole single-word frame, then time for the bank to settle
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.start();
        host.word({a, d});
        host.stop();
        repeat (8) @(posedge i_clk);
    endtask
    // channel order: low nibble runs ch1 at d3 down to ch4 at d0
    function automatic logic [7:0] chmap(input logic [7:0] d);
        return {d[7:4], d[0], d[1], d[2], d[3]};
    endfunction
    // counts gain link rises; bounded, so a dead link cannot hang
    task automatic grab(input int lim);
        logic p;
        n = 0;
        p = gclk;
        for (int i = 0; i < lim && n < 40; i++) begin
            @(posedge i_clk);
            if (gclk && !p) begin
                vec[n] = gdat;
                n++;
            end
            p = gclk;
        end
    endtask

    task automatic s_power();
        host.start();
        host.word({8'h0f, 16'h02c1});
        repeat (10) @(posedge i_clk);
        exp_c.channel_power_down = chmap(8'hc1);
        exp_c.full_sleep = 1'b1;
        ck("power word one");
        host.word({8'h0f, 16'h0501});
        host.stop();
        repeat (8) @(posedge i_clk);
        exp_c.channel_power_down = chmap(8'h01);
        exp_c.full_sleep = 1'b0;
        exp_c.partial_sleep = 1'b1;
        exp_c.sleep_pin_config = 1'b1;
        ck("power word two");
    endtask
    task automatic s_drive();
        host.start();
        host.word({8'h11, 16'h0531});
        host.word({8'h12, 16'h0267});
        host.stop();
        repeat (8) @(posedge i_clk);
        exp_c.bitclk_drive_code = 3'h1;
        exp_c.frameclk_drive_code = 3'h3;
        exp_c.data_drive_code = 3'h5;
        ck("drive codes");
        wr(8'h12, 16'h4267);
        exp_c.term_enable = 1'b1;
        exp_c.bitclk_term_code = 3'h7;
        exp_c.frameclk_term_code = 3'h6;
        exp_c.data_term_code = 3'h2;
        ck("termination");
    endtask
    // trailing bits and unmapped tuning words leave the bank alone
    task automatic s_tail();
        host.start();
        host.word({8'h14, 16'h0031});
        host.bits8(8'h14);
        host.bits8(8'h00);
        host.stop();
        repeat (8) @(posedge i_clk);
        exp_c.low_freq_suppress_enable = chmap(8'h31);
        ck("partial word");
        host.start();
        host.word({8'h01, 16'h0010});
        host.word({8'hd1, 16'h0140});
        host.word({8'hda, 16'h0001});
        host.word({8'he1, 16'h0020});
        host.word({8'h02, 16'h0080});
        host.word({8'h01, 16'h0000});
        host.stop();
        repeat (8) @(posedge i_clk);
        ck("unmapped words");
    endtask
    task automatic s_pattern();
        for (int b = 4; b < 7; b++) begin
            host.start();
            host.word({8'h25, 16'h0009 | (16'h0001 << b)});
            host.word({8'h26, 10'h2a5, 6'h00});
            host.word({8'h27, 10'h15a, 6'h00});
            host.stop();
            repeat (8) @(posedge i_clk);
            exp_c.one_code_pattern_enable = (b == 4);
            exp_c.two_code_pattern_enable = (b == 5);
            exp_c.ramp_enable = (b == 6);
            exp_c.first_custom_code = {2'b01, 10'h2a5};
            exp_c.second_custom_code = {2'b10, 10'h15a};
            ck("pattern");
        end
    endtask
    task automatic s_gain();
        wr(8'h16, 16'hbeef);
        grab(400);
        cmp("gain rises while off", '0, CW'(n));
        gen <= 1'b1;
        host.start();
        host.word({8'h16, 16'hbeef});
        host.word({8'h17, 16'h5a3c});
        host.stop();
        repeat (400) @(posedge i_clk);
        fork
            wr(8'h18, 16'h00c7);
            grab(2000);
        join
        cmp("gain rises", CW'(40), CW'(n));
        cmp("gain vector", CW'(40'hc75a3cbeef), CW'(vec));
    endtask
    task automatic s_resets();
        wr(8'h03, 16'h0000);
        exp_c.gain_ctrl_select = 1'b0;
        ck("gain select");
        wr(8'h00, 16'h0020);
        exp_c = def_c;
        ck("soft reset");
        wr(8'h14, 16'h0031);
        exp_c.low_freq_suppress_enable = chmap(8'h31);
        ck("after soft reset");
        @(posedge i_clk) hw_n <= 1'b0;
        repeat (5) @(posedge i_clk);
        hw_n <= 1'b1;
        repeat (6) @(posedge i_clk);
        exp_c = def_c;
        ck("pin reset");
    endtask

    // main sequence
    initial begin
        def_c = '0;
        def_c.gain_ctrl_select = 1'b1;
        exp_c = def_c;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (5) @(posedge i_clk);
        ck("reset defaults");
        wr(8'h00, 16'h0020);
        ck("initialised");
        s_power();
        s_drive();
        s_tail();
        s_pattern();
        s_gain();
        s_resets();
        close_out();
    end
endmodule
